//--- hw/pwm_control_and_match_irq.sv
// Notes on behaviour
// R01 - keeps running in sleep on internal oscillators
// R02 - four separate match interrupt sources
// R03 - flags set on rising edge of match
// R04 - bit 7 enables or disables the channel
// R05 - bit 5 shows output level, read only
// R06 - bit 4 set makes active level low
// R07 - bits 3-2 select one of four modes
// R08 - unimplemented control bits read as zero
// R09 - control bits clear on every reset
// R10 - flags stay set until software clears
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`include "pwm_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_control_and_match_irq #(
  parameter int ADDR_WIDTH = 5
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADDR_WIDTH-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_sleep,
  input wire pwm_ctrl_pkg::match_t i_match,
  input wire logic i_active,
  output logic o_pwm_out,
  output pwm_ctrl_pkg::config_t o_config,
  output logic o_irq
);

  // register state
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic [1:0] clksel_q;
  logic [1:0] clksel_d;
  logic [3:0] match_prev_q;
  logic [3:0] snap_q;
  logic out_q;
  logic out_d;
  logic irq_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  pwm_ctrl_pkg::config_t config_q;
  pwm_ctrl_pkg::config_t config_d;

  // bus decode
  wire request = i_read | i_write;
  wire capture = request & wait_q;
  wire done = request & ~wait_q;
  wire aligned = (i_address[1:0] == 2'h0);
  wire hit_control = aligned & (i_address == ADDR_WIDTH'(`OFS_CONTROL));
  wire hit_status = aligned & (i_address == ADDR_WIDTH'(`OFS_STATUS));
  wire hit_mask = aligned & (i_address == ADDR_WIDTH'(`OFS_MASK));
  wire hit_clksel = aligned & (i_address == ADDR_WIDTH'(`OFS_CLOCK_SELECT));
  wire wr_low = done & i_write & i_byteenable[0];
  wire wr_control = wr_low & hit_control;
  wire wr_mask = wr_low & hit_mask;
  wire wr_clksel = wr_low & hit_clksel;
  wire rd_status_done = done & i_read & hit_status;

  // match edges; a level held high sets the flag only once
  wire [3:0] match_now = i_match;
  wire [3:0] match_rise = match_now & ~match_prev_q; // R03 R02

  // a read of status clears only what it reported, so new events survive
  wire [3:0] clear_bits = rd_status_done ? snap_q : 4'h0;

  // sleep stops the channel unless it runs from one of the two internal oscillators
  wire internal_osc = (clksel_q == pwm_ctrl_pkg::CLK_FAST_INTERNAL_OSC) ||
                      (clksel_q == pwm_ctrl_pkg::CLK_SLOW_INTERNAL_OSC);
  wire run = control_q[`BIT_ENABLE] & (~i_sleep | internal_osc); // R01 R04

  // control image as software sees it
  wire [7:0] control_view = (control_q & `CONTROL_WMASK) |
                            (8'(out_q) << `BIT_OUT_STATE); // R05 R08

  // control register next value
  always_comb
  begin
    control_d = control_q;
    if (wr_control)
    begin
      control_d = i_writedata[7:0] & `CONTROL_WMASK; // R04 R06 R07 R08
    end
  end

  // status flags: the set wins over a same-cycle clear
  always_comb
  begin
    status_d = (status_q & ~clear_bits) | match_rise; // R10 R03
  end

  // mask and clock select
  always_comb
  begin
    mask_d = mask_q;
    clksel_d = clksel_q;
    if (wr_mask)
    begin
      mask_d = i_writedata[3:0];
    end
    if (wr_clksel)
    begin
      clksel_d = i_writedata[1:0];
    end
  end

  // output level; held while the channel is stalled in sleep
  always_comb
  begin
    out_d = out_q;
    if (!control_q[`BIT_ENABLE])
    begin
      out_d = control_q[`BIT_POLARITY];
    end
    else if (run)
    begin
      out_d = i_active ^ control_q[`BIT_POLARITY]; // R06 R01
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb
  begin
    rdata_d = `DATA_ZERO;
    if (hit_control)
    begin
      rdata_d[7:0] = control_view; // R05 R08
    end
    else if (hit_status)
    begin
      rdata_d[3:0] = status_q;
    end
    else if (hit_mask)
    begin
      rdata_d[3:0] = mask_q;
    end
    else if (hit_clksel)
    begin
      rdata_d[1:0] = clksel_q;
    end
  end

  // settings for the counter logic
  always_comb
  begin
    config_d.enable = control_q[`BIT_ENABLE];
    config_d.polarity_select = control_q[`BIT_POLARITY];
    config_d.mode = pwm_ctrl_pkg::mode_t'(control_q[`BIT_MODE_HI:`BIT_MODE_LO]); // R07
    config_d.clock_select = pwm_ctrl_pkg::clock_select_t'(clksel_q);
    config_d.run = run;
  end

  // register update; every reset kind lands here
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      control_q <= `CONTROL_RESET; // R09
      status_q <= `STATUS_RESET;
      mask_q <= `MASK_RESET;
      clksel_q <= `CLKSEL_RESET;
      out_q <= 1'b0;
    end
    else
    begin
      control_q <= control_d;
      status_q <= status_d;
      mask_q <= mask_d;
      clksel_q <= clksel_d;
      out_q <= out_d;
    end
  end

  // edge history and derived outputs
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      match_prev_q <= 4'h0;
      irq_q <= 1'b0;
      config_q <= '0;
    end
    else
    begin
      match_prev_q <= match_now;
      irq_q <= |(status_d & mask_d);
      config_q <= config_d;
    end
  end

  // bus handshake: one wait cycle, data latched at capture
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wait_q <= 1'b1;
      rdata_q <= `DATA_ZERO;
      snap_q <= 4'h0;
    end
    else
    begin
      wait_q <= ~capture;
      if (capture & i_read)
      begin
        rdata_q <= rdata_d;
        snap_q <= hit_status ? status_q : 4'h0;
      end
    end
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_pwm_out = out_q;
  assign o_config = config_q;
  assign o_irq = irq_q;

  // checks
  property p_flag_on_rise;
    @(posedge i_clk) disable iff (i_reset)
    match_rise[0] |=> status_q[0];
  endproperty
  a_flag_on_rise: assert property (p_flag_on_rise) // R03
    else $error("phase flag not set on rising match");

  property p_no_set_on_level;
    @(posedge i_clk) disable iff (i_reset)
    (!status_q[1] && i_match.duty && match_prev_q[1]) |=> !status_q[1];
  endproperty
  a_no_set_on_level: assert property (p_no_set_on_level) // R03
    else $error("duty flag set by a held match");

  property p_flags_independent;
    @(posedge i_clk) disable iff (i_reset)
    (match_rise == 4'h4 && status_q == 4'h0 && !rd_status_done) |=> (status_q == 4'h4);
  endproperty
  a_flags_independent: assert property (p_flags_independent) // R02
    else $error("period event touched other flags");

  property p_flag_sticky;
    @(posedge i_clk) disable iff (i_reset)
    (status_q[3] && !rd_status_done && !capture) |=> status_q[3] [*2];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R10
    else $error("offset flag dropped without a status read");

  property p_enable_write;
    @(posedge i_clk) disable iff (i_reset)
    wr_control |=> (control_q[`BIT_ENABLE] == $past(i_writedata[`BIT_ENABLE])) ##1
      (o_config.enable == $past(control_q[`BIT_ENABLE]));
  endproperty
  a_enable_write: assert property (p_enable_write) // R04
    else $error("enable bit did not follow the write");

  property p_out_state_read;
    @(posedge i_clk) disable iff (i_reset)
    (capture && i_read && hit_control) |=> (o_readdata[`BIT_OUT_STATE] == $past(out_q));
  endproperty
  a_out_state_read: assert property (p_out_state_read) // R05
    else $error("out state bit differs from output");

  property p_polarity;
    @(posedge i_clk) disable iff (i_reset)
    run |=> (o_pwm_out == ($past(i_active) ^ $past(control_q[`BIT_POLARITY])));
  endproperty
  a_polarity: assert property (p_polarity) // R06
    else $error("output level ignores polarity");

  property p_mode_write;
    @(posedge i_clk) disable iff (i_reset)
    wr_control |-> ##2 (o_config.mode == $past(i_writedata[`BIT_MODE_HI:`BIT_MODE_LO], 2));
  endproperty
  a_mode_write: assert property (p_mode_write) // R07
    else $error("mode field not taken from write");

  property p_unimplemented_zero;
    @(posedge i_clk) disable iff (i_reset)
    (capture && i_read && hit_control) |=> (o_readdata[6] == 1'b0 && o_readdata[1:0] == 2'h0);
  endproperty
  a_unimplemented_zero: assert property (p_unimplemented_zero) // R08
    else $error("unimplemented control bit read as one");

  property p_reset_clears;
    @(posedge i_clk)
    i_reset |=> (control_q == 8'h00 && o_config.enable == 1'b0 || i_reset);
  endproperty
  a_reset_clears: assert property (p_reset_clears) // R09
    else $error("control not cleared by reset");

  property p_sleep_run;
    @(posedge i_clk) disable iff (i_reset)
    (control_q[`BIT_ENABLE] && i_sleep && internal_osc) |=> o_config.run;
  endproperty
  a_sleep_run: assert property (p_sleep_run) // R01
    else $error("channel stopped in sleep on internal osc");

  property p_one_wait;
    @(posedge i_clk) disable iff (i_reset)
    (request && wait_q) |=> !o_waitrequest ##1 o_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest not low for exactly one cycle");

endmodule : pwm_control_and_match_irq

`default_nettype wire

//--- hw/pwm_ctrl_defines.svh
`ifndef PWM_CTRL_DEFINES_SVH
`define PWM_CTRL_DEFINES_SVH
// register byte offsets on the avalon slave
`define OFS_CONTROL 5'h00
`define OFS_STATUS 5'h04
`define OFS_MASK 5'h08
`define OFS_CLOCK_SELECT 5'h0c
// control register fields
`define BIT_ENABLE 7
`define BIT_OUT_STATE 5
`define BIT_POLARITY 4
`define BIT_MODE_HI 3
`define BIT_MODE_LO 2
// writable bits of the control register
`define CONTROL_WMASK 8'h9c
`define CONTROL_RESET 8'h00
`define STATUS_RESET 4'h0
`define MASK_RESET 4'h0
`define CLKSEL_RESET 2'h0
`define MATCH_COUNT 4
`define DATA_ZERO 32'h0000_0000
`endif

//--- hw/pwm_ctrl_pkg.sv
package pwm_ctrl_pkg;

  // operating modes of the counter logic
  typedef enum logic [1:0] {
    MODE_STANDARD = 2'h0,
    MODE_SET_ON_MATCH = 2'h1,
    MODE_TOGGLE_ON_MATCH = 2'h2,
    MODE_CENTER_ALIGNED = 2'h3
  } mode_t;

  // clock source choices for the channel
  typedef enum logic [1:0] {
    CLK_SYSTEM = 2'h0,
    CLK_FAST_INTERNAL_OSC = 2'h1,
    CLK_SLOW_INTERNAL_OSC = 2'h2,
    CLK_RESERVED = 2'h3
  } clock_select_t;

  // the four match events, bit order as in status and mask
  typedef struct packed {
    logic offset;
    logic period;
    logic duty;
    logic phase;
  } match_t;

  // settings handed to the counter and comparator logic
  typedef struct packed {
    logic enable;
    logic polarity_select;
    mode_t mode;
    clock_select_t clock_select;
    logic run;
  } config_t;

endpackage : pwm_ctrl_pkg

//--- testbench/pwm_control_and_match_irq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_control_and_match_irq_tb_top;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic slp = 1'b0;
  pwm_ctrl_pkg::match_t mt = 4'h0;
  logic act = 1'b0;
  logic o_pwm_out;
  pwm_ctrl_pkg::config_t o_config;
  logic o_irq;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] rdat;
  logic [31:0] w;
  logic a;

  pwm_control_and_match_irq pwm_control_and_match_irq_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_address(adr), .i_read(rd), .i_write(wr),
    .i_writedata(wd), .i_byteenable(be), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_sleep(slp), .i_match(mt), .i_active(act), .o_pwm_out(o_pwm_out), .o_config(o_config), .o_irq(o_irq)
  );

  // free running 100 mhz clock
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task bus(input logic is_wr, input logic [4:0] ad, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    rd <= !is_wr;
    wr <= is_wr;
    adr <= ad;
    wd <= d;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (o_waitrequest !== 1'b0 && k < 20);
    rdat = o_readdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20)
    begin
      n_mismatch++;
      $display("[FAIL] %0t bus answer never came", $time);
      conclude();
    end
  endtask : bus

  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  // disabled pin sits at the inactive level
  function automatic logic exp_out(input logic [31:0] c, input logic s);
    return c[7] ? (s ^ c[4]) : c[4];
  endfunction : exp_out

  initial
  begin
    void'($urandom(32'ha70f));
    cyc(2);
    i_reset <= 1'b0;
    // every register starts cleared
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b0, 5'(r * 4), 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
    end
    // random control values, every mode, out bit written opposite
    for (int m = 0; m < 4; m++)
    begin
      w = $urandom;
      a = w[8];
      w[3:2] = 2'(m);
      w[5] = ~exp_out(w, a);
      act <= a;
      bus(1'b1, 5'h00, w);
      cyc(3);
      chk(32'(o_pwm_out), 32'(exp_out(w, a)));
      bus(1'b0, 5'h00, 32'h0000_0000);
      chk(rdat, (w & 32'h0000_009c) | 32'(exp_out(w, a)) << 5);
      chk(32'(o_config.mode), 32'(m));
      chk(32'(o_config.enable), 32'(w[7]));
      chk(32'(o_config.polarity_select), 32'(w[4]));
    end
    // lane 0 disabled: write dropped
    be <= 4'h0;
    bus(1'b1, 5'h00, 32'h0000_0010);
    be <= 4'hf;
    bus(1'b0, 5'h00, 32'h0000_0000);
    chk(rdat, (w & 32'h0000_009c) | 32'(exp_out(w, a)) << 5);
    // sleep: only the internal oscillators keep the pin moving
    bus(1'b1, 5'h00, 32'h0000_0080);
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, 5'h0c, 32'(s));
      bus(1'b0, 5'h0c, 32'h0000_0000);
      chk(rdat, 32'(s));
      act <= 1'b0;
      cyc(3);
      slp <= 1'b1;
      cyc(2);
      act <= 1'b1;
      cyc(3);
      chk(32'(o_pwm_out), 32'(s == 1 || s == 2));
      chk(32'(o_config.run), 32'(s == 1 || s == 2));
      chk(32'(o_config.clock_select), 32'(s));
      slp <= 1'b0;
      cyc(3);
      chk(32'(o_pwm_out), 32'h0000_0001);
    end
    // each match source, sticky flag and edge detection
    bus(1'b1, 5'h08, 32'h0000_000f);
    for (int b = 0; b < 4; b++)
    begin
      mt <= 4'(1 << b);
      cyc(2);
      mt <= 4'h0;
      cyc(5);
      chk(32'(o_irq), 32'h0000_0001);
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rdat, 32'(1 << b));
      mt <= 4'(1 << b);
      cyc(3);
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rdat, 32'(1 << b));
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      chk(32'(o_irq), 32'h0000_0000);
      mt <= 4'h0;
      // let the low level reach the edge detector before the next source
      cyc(1);
    end
    // random mask against all four events at once
    w = $urandom & 32'h0000_000f;
    bus(1'b1, 5'h08, w);
    mt <= 4'hf;
    cyc(3);
    chk(32'(o_irq), 32'(w != 0));
    bus(1'b0, 5'h04, 32'h0000_0000);
    chk(rdat, 32'h0000_000f);
    mt <= 4'h0;
    // unmapped and misaligned places are ignored
    act <= 1'b0;
    bus(1'b1, 5'h10, 32'h0000_00ff);
    bus(1'b1, 5'h01, 32'h0000_00ff);
    bus(1'b0, 5'h00, 32'h0000_0000);
    chk(rdat, 32'h0000_0080);
    bus(1'b0, 5'h1d, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    // second reset in mid-run
    i_reset <= 1'b1;
    cyc(2);
    i_reset <= 1'b0;
    bus(1'b0, 5'h00, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk(32'(o_config), 32'h0000_0000);
    conclude();
  end
endmodule : pwm_control_and_match_irq_tb_top
`default_nettype wire
